// ---- hdl/sdadc_pkg.sv ----
// Purpose: shared constants and carrier types for the sigma-delta converter control
// Assumes: 16-bit register port, 125 MHz system clock
// Notes: all offsets are byte addresses on the register port
package sdadc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [15:0] ADDR_RESULT = 16'h4900;
	localparam logic [15:0] ADDR_CONFIG = 16'h4902;
	localparam logic [15:0] ADDR_FLAG = 16'h4A00;
	localparam logic [15:0] ADDR_MASK = 16'h4A02;
	localparam logic [15:0] ADDR_MISS = 16'h4A04;

	// Config fields
	localparam int RATE_LSB = 12;
	localparam int SEL_LSB = 8;
	localparam int DITH_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [15:0] CFG_WMASK = 16'h7F03;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	// Converter event bit in flag, mask and miss registers
	localparam int EVT_BIT = 11;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int SYS_CLK_HZ = 125_000_000;
	localparam int MOD_RATE_HZ = 1_000_000;
	localparam int MOD_DIV = SYS_CLK_HZ / MOD_RATE_HZ;
	localparam int DIV_W = 8;
	localparam int CONV_BASE_US = 32;
	localparam int BASE_SAMPLES = CONV_BASE_US * (MOD_RATE_HZ / 1_000_000);
	localparam int RES_BASE_BITS = 5;
	localparam int CNT_W = 13;

	////////////////////////////////////////////////////////////////////////
	// Input select codes
	typedef enum logic [3:0] {
		SEL_SE0 = 4'h0,
		SEL_SE1 = 4'h1,
		SEL_SE2 = 4'h2,
		SEL_SE3 = 4'h3,
		SEL_PAD_SUPPLY_QTR = 4'h4,
		SEL_CORE_HALF = 4'h5,
		SEL_RESERVED = 4'h6,
		SEL_GROUND = 4'h7,
		SEL_REFERENCE = 4'h8,
		SEL_DIFF01 = 4'h9,
		SEL_DIFF23 = 4'hA
	} input_sel_t;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic clk;
		logic ditherOff;
		logic [3:0] inputSel;
		logic refOutEn;
	} mod_ctrl_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] ones;
		logic done;
		logic [15:0] result;
	} dec_state_t;

	typedef struct packed {
		logic [15:0] cfg;
		logic flag;
		logic mask;
		logic miss;
		logic irq;
		logic [15:0] result;
		logic [15:0] rdata;
		logic [DIV_W-1:0] divCnt;
		logic sync1;
		logic sync2;
		mod_ctrl_t mod;
	} top_state_t;

endpackage

// ---- hdl/sigma_delta_decimator.sv ----
// Purpose: counts modulator ones over one conversion window and left-aligns the result
// Assumes: sampleEn is a one-cycle pulse per modulator sample
// Notes: clearing run drops the window in progress
module sigma_delta_decimator (
	// Clock and reset
	input wire logic clk,
	input wire logic rstSyncN,
	// Control
	input wire logic run,
	input wire logic [2:0] rate,
	// Modulator stream
	input wire logic sampleEn,
	input wire logic bitIn,
	// Result
	output logic done,
	output logic [15:0] result
);
	import sdadc_pkg::*;

	dec_state_t st_ff;
	dec_state_t nxt_st;

	always_comb begin
		logic [CNT_W-1:0] total;
		logic [CNT_W-1:0] ones1;
		logic [CNT_W-1:0] val;
		total = CNT_W'(BASE_SAMPLES << rate);
		ones1 = st_ff.ones + CNT_W'(bitIn);
		val = '0;
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (!run) begin
			nxt_st.cnt = '0;
			nxt_st.ones = '0;
		end else if (sampleEn) begin
			if (st_ff.cnt == total - CNT_W'(1)) begin
				// Full count would overflow the field by one
				val = (ones1 == total) ? total - CNT_W'(1) : ones1;
				nxt_st.result = 16'(32'(val) << (16 - RES_BASE_BITS - int'(rate)));
				nxt_st.done = 1'b1;
				nxt_st.cnt = '0;
				nxt_st.ones = '0;
			end else begin
				nxt_st.cnt = st_ff.cnt + CNT_W'(1);
				nxt_st.ones = ones1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done = st_ff.done;
	assign result = st_ff.result;

	a_low_bits_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
		st_ff.done |-> (st_ff.result & (16'hFFFF >> (RES_BASE_BITS + int'(rate)))) == 16'h0000)
		else $error("result bits below resolution not zero");

endmodule

// ---- hdl/sigma_delta_adc_control.sv ----
// Purpose: register, timing and event control of a first-order sigma-delta converter
// Assumes: analog modulator returns one bit per modulator clock
// Notes: event pulse is one system clock wide
module sigma_delta_adc_control #(
	parameter int CLK_HZ = sdadc_pkg::SYS_CLK_HZ
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire sdadc_pkg::reg_req_t regReq,
	output logic [15:0] regRdata,
	// Processor interrupt
	output logic irqOut,
	// Modulator front end
	input wire logic modBit,
	output sdadc_pkg::mod_ctrl_t modCtrl
);
	import sdadc_pkg::*;

	localparam int DIV = CLK_HZ / MOD_RATE_HZ;
	localparam int HALF = DIV / 2;

	if (DIV < 4 || DIV > (1 << DIV_W) || CLK_HZ % MOD_RATE_HZ != 0) begin : g_bad_clk
		$error("clock rate cannot produce the modulator rate");
	end

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rstMeta_ff;
	logic rstSync_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State

	top_state_t st_ff;
	top_state_t nxt_st;
	logic decDone;
	logic [15:0] decResult;
	logic sampleEn;
	logic convEn;
	logic flagClr;
	logic missClr;
	logic missEvt;

	assign convEn = st_ff.cfg[EN_BIT];
	// Sample just after the modulator clock falls, bit has settled through sync
	assign sampleEn = convEn && (st_ff.divCnt == DIV_W'(HALF));
	assign flagClr = regReq.wr && (regReq.addr == ADDR_FLAG) && regReq.wdata[EVT_BIT];
	assign missClr = regReq.wr && (regReq.addr == ADDR_MISS) && regReq.wdata[EVT_BIT];
	// Event while the previous one is still pending and enabled
	assign missEvt = decDone && st_ff.mask && st_ff.flag && !flagClr;

	////////////////////////////////////////////////////////////////////////
	// Decimation filter

	sigma_delta_decimator u_dec (
		.clk(sys_clk),
		.rstSyncN(rstSync_ff),
		.run(convEn),
		.rate(st_ff.cfg[RATE_LSB+:3]),
		.sampleEn(sampleEn),
		.bitIn(st_ff.sync2),
		.done(decDone),
		.result(decResult)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [DIV_W-1:0] nxtDiv;
		logic [15:0] rd;
		// Parked on its last count so the first period after enable is a full one
		nxtDiv = DIV_W'(DIV - 1);
		rd = 16'h0000;
		nxt_st = st_ff;

		// Config write; reserved bits never stored
		if (regReq.wr && regReq.addr == ADDR_CONFIG) begin
			nxt_st.cfg = regReq.wdata & CFG_WMASK;
		end
		if (regReq.wr && regReq.addr == ADDR_MASK) begin
			nxt_st.mask = regReq.wdata[EVT_BIT];
		end

		// Modulator clock divider, idle low while disabled
		if (convEn) begin
			nxtDiv = (st_ff.divCnt == DIV_W'(DIV - 1)) ? '0 : st_ff.divCnt + DIV_W'(1);
		end
		nxt_st.divCnt = nxtDiv;
		nxt_st.mod.clk = convEn && (nxtDiv < DIV_W'(HALF));

		// Two-stage sync of the modulator bit
		nxt_st.sync1 = modBit;
		nxt_st.sync2 = st_ff.sync1;

		// Sample register only moves on completion; writes have no effect
		if (decDone) begin
			nxt_st.result = decResult;
		end

		// Set wins over the write-one clear
		nxt_st.flag = decDone || (st_ff.flag && !flagClr);
		nxt_st.miss = missEvt || (st_ff.miss && !missClr);
		nxt_st.irq = st_ff.flag && st_ff.mask;

		// Front-end controls follow config directly
		nxt_st.mod.ditherOff = nxt_st.cfg[DITH_BIT];
		nxt_st.mod.inputSel = nxt_st.cfg[SEL_LSB+:4];
		nxt_st.mod.refOutEn = nxt_st.cfg[EN_BIT];

		// Read data valid only in the cycle after the strobe
		if (regReq.rd) begin
			case (regReq.addr)
				ADDR_RESULT: rd = st_ff.result;
				ADDR_CONFIG: rd = st_ff.cfg;
				ADDR_FLAG: rd[EVT_BIT] = st_ff.flag;
				ADDR_MASK: rd[EVT_BIT] = st_ff.mask;
				ADDR_MISS: rd[EVT_BIT] = st_ff.miss;
				default: rd = 16'h0000;
			endcase
		end
		nxt_st.rdata = rd;
	end

	always_ff @(posedge sys_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			st_ff <= '0;
			st_ff.cfg <= CFG_RESET;
			st_ff.result <= RESULT_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign regRdata = st_ff.rdata;
	assign irqOut = st_ff.irq;
	assign modCtrl = st_ff.mod;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstSync_ff);

	a_flag_set_wins: assert property (decDone |=> st_ff.flag)
		else $error("done event did not set pending flag");

	a_flag_w1c: assert property (flagClr && !decDone |=> !st_ff.flag)
		else $error("write one did not clear pending flag");

	a_done_one_cycle: assert property (decDone |=> !decDone)
		else $error("done event longer than one cycle");

	a_result_update: assert property (decDone |=> st_ff.result == $past(decResult))
		else $error("sample register not updated on completion");

	a_result_read_only: assert property (regReq.wr && regReq.addr == ADDR_RESULT && !decDone
		|=> st_ff.result == $past(st_ff.result))
		else $error("sample register changed on write");

	a_cfg_zero_bits: assert property (regReq.rd && regReq.addr == ADDR_CONFIG
		|=> (regRdata & ~CFG_WMASK) == 16'h0000)
		else $error("reserved config bits read nonzero");

	a_ref_follows_en: assert property (regReq.wr && regReq.addr == ADDR_CONFIG
		|=> modCtrl.refOutEn == $past(regReq.wdata[EN_BIT]))
		else $error("reference output not tied to enable");

	a_irq_masked: assert property (irqOut |-> $past(st_ff.flag) && $past(st_ff.mask))
		else $error("interrupt raised without pending and mask");

	a_miss_record: assert property (decDone && st_ff.mask && st_ff.flag && !flagClr
		|=> st_ff.miss)
		else $error("missed event not recorded");

	a_mod_period: assert property ((convEn && $rose(modCtrl.clk)) ##DIV convEn
		|-> $rose(modCtrl.clk))
		else $error("modulator clock not one megahertz");

	a_mod_idle: assert property (!convEn ##1 !convEn |-> !modCtrl.clk)
		else $error("modulator clock running while disabled");

endmodule

// ---- bench/sdadc_modulator_model.sv ----
// Purpose: behavioural modulator front end for the converter control bench
// Assumes: the bench sets level to stand for the analog input
// Notes: one bit per modulator clock rise
module sdadc_modulator_model (
	// Clock
	input wire logic sys_clk,
	// Control from the block, level from the bench
	input wire sdadc_pkg::mod_ctrl_t modCtrl,
	input wire logic level,
	// Bit stream
	output logic modBit
);
	timeunit 1ns;
	timeprecision 1ps;
	import sdadc_pkg::*;
	logic prevClk = 1'b0;
	initial modBit = 1'b0;
	always @(posedge sys_clk) begin
		prevClk <= modCtrl.clk;
		// Off: churn, so a stale bit never looks valid
		if (!modCtrl.refOutEn)
			modBit <= ~modBit;
		else if (modCtrl.clk && !prevClk)
			modBit <= level;
	end
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the sigma-delta converter control
// Assumes: CLK_HZ lowered so a modulator clock is four system clocks
// Notes: level held constant per run, so results are full or zero scale
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sdadc_pkg::*;
	localparam int HZ = 4_000_000;
	localparam int DIV = HZ / 1_000_000;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic level = 1'b0;
	logic modBit;
	reg_req_t regReq = '0;
	logic [15:0] regRdata;
	logic irqOut;
	mod_ctrl_t modCtrl;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	sigma_delta_adc_control #(.CLK_HZ(HZ)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
		.regRdata(regRdata), .irqOut(irqOut), .modBit(modBit), .modCtrl(modCtrl));
	sdadc_modulator_model model (.sys_clk(sys_clk), .modCtrl(modCtrl), .level(level), .modBit(modBit));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regReq.addr <= a;
		regReq.wdata <= d;
		regReq.wr <= 1'b1;
		@(posedge sys_clk);
		regReq.wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [15:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		regReq.addr <= a;
		regReq.rd <= 1'b1;
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
		@(negedge sys_clk);
		chk(what, regRdata, exp);
	endtask
	// Waits for a fresh rise, so a level left from the last event is skipped
	task automatic waitIrq(output int t);
		int n;
		n = 0;
		while (irqOut !== 1'b0 && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		while (irqOut !== 1'b1 && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("irqWait", {15'h0, n < 20000}, 16'h0001);
		chk("irqOut", {15'h0, irqOut}, 16'h0001);
		t = cyc;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic regs();
		rchk("cfgReset", ADDR_CONFIG, CFG_RESET);
		rchk("resultReset", ADDR_RESULT, RESULT_RESET);
		rchk("unmapped", 16'h4904, 16'h0000);
		wr(ADDR_CONFIG, 16'hFFFF);
		@(negedge sys_clk);
		chk("ditherOff", {15'h0, modCtrl.ditherOff}, 16'h0001);
		chk("refOutOn", {15'h0, modCtrl.refOutEn}, 16'h0001);
		rchk("cfgMask", ADDR_CONFIG, 16'h7F03);
		wr(ADDR_RESULT, 16'h1234);
		rchk("resultRo", ADDR_RESULT, 16'h0000);
		for (int s = 0; s <= 10; s++) begin
			wr(ADDR_CONFIG, 16'(s << SEL_LSB));
			@(negedge sys_clk);
			chk("inputSel", {12'h0, modCtrl.inputSel}, 16'(s));
			chk("ditherOn", {15'h0, modCtrl.ditherOff}, 16'h0000);
		end
	endtask
	task automatic convRate(input int r);
		int t1;
		int t2;
		wr(ADDR_CONFIG, 16'h0000);
		wr(ADDR_FLAG, 16'h0800);
		wr(ADDR_MASK, 16'h0800);
		level = 1'b1;
		wr(ADDR_CONFIG, 16'(r << RATE_LSB) | 16'h0001);
		// Cycle count read off the edge, clear of the counter's own update
		@(posedge modCtrl.clk);
		@(negedge sys_clk);
		t1 = cyc;
		@(posedge modCtrl.clk);
		@(negedge sys_clk);
		t2 = cyc;
		chk("modClkPeriod", 16'(t2 - t1), 16'(DIV));
		waitIrq(t1);
		wr(ADDR_FLAG, 16'h0800);
		waitIrq(t2);
		chk("convCycles", 16'(t2 - t1), 16'((32 << r) * DIV));
		rchk("result", ADDR_RESULT, 16'(((32 << r) - 1) << (11 - r)));
	endtask
	task automatic missMask();
		int t;
		wr(ADDR_CONFIG, 16'h0000);
		wr(ADDR_FLAG, 16'h0800);
		level = 1'b0;
		wr(ADDR_CONFIG, 16'h0001);
		waitIrq(t);
		wr(ADDR_FLAG, 16'h0800);
		waitIrq(t);
		rchk("resultZero", ADDR_RESULT, 16'h0000);
		repeat (32 * DIV + 8) @(posedge sys_clk);
		rchk("missSet", ADDR_MISS, 16'h0800);
		wr(ADDR_MASK, 16'h0000);
		wr(ADDR_MISS, 16'h0800);
		rchk("missClear", ADDR_MISS, 16'h0000);
		wr(ADDR_FLAG, 16'h0800);
		rchk("flagClear", ADDR_FLAG, 16'h0000);
		repeat (32 * DIV + 8) @(posedge sys_clk);
		chk("irqMasked", {15'h0, irqOut}, 16'h0000);
		rchk("flagMasked", ADDR_FLAG, 16'h0800);
		wr(ADDR_CONFIG, 16'h0000);
		@(negedge sys_clk);
		chk("refOutOff", {15'h0, modCtrl.refOutEn}, 16'h0000);
		// Modulator clock settles low one edge after the disable
		@(negedge sys_clk);
		chk("modClkIdle", {15'h0, modCtrl.clk}, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		regs();
		for (int r = 0; r < 3; r++)
			convRate(r);
		missMask();
		summarize();
	end
	// Whole run needs about 20 us
	initial begin
		#200_000;
		num_errors++;
		summarize();
	end
endmodule
